//--- inc/urd_pkg.sv
// constants, states and helpers shared by the serial port datapath
package urd_pkg;
  // register byte offsets
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_BAUD = 4'hC;
  // format_control_reg bit positions
  localparam int CTRL_WORD9 = 0;
  localparam int CTRL_PAR_EN = 1;
  localparam int CTRL_PAR_ODD = 2;
  localparam int CTRL_STOP2 = 3;
  localparam int CTRL_TX_NINTH = 4;
  localparam int CTRL_RX_NINTH = 5;
  localparam int CTRL_TX_EN = 6;
  localparam int CTRL_RX_EN = 7;
  localparam int CTRL_BREAK = 8;
  localparam int CTRL_TX_IRQ_EN = 9;
  localparam int CTRL_RX_IRQ_EN = 10;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK = 16'h07DF;
  // port_status_reg bit positions
  localparam int STAT_TX_EMPTY = 0;
  localparam int STAT_TX_IDLE = 1;
  localparam int STAT_RX_AVAIL = 2;
  localparam int STAT_OVERRUN = 3;
  localparam int STAT_NOISE = 4;
  localparam int STAT_FRAME = 5;
  localparam int STAT_PARITY = 6;
  localparam int STAT_RX_IDLE = 7;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  // bit timing in oversample ticks, bit counts
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] RX_SAMPLE_PHASE = 4'h6;
  localparam logic [3:0] BREAK_LAST = 4'hC;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;
  localparam logic [1:0] FIFO_FULL = 2'h2;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_BREAK, TX_STOP} urd_tx_state_e;
  typedef enum logic [2:0] {RX_WAITHIGH, RX_HUNT, RX_START, RX_DATA, RX_STOP} urd_rx_state_e;

  // parity over the data bits that precede the parity position
  function automatic logic urd_par(input logic [8:0] w, input logic word9, input logic odd);
    urd_par = (word9 ? ^w[7:0] : ^w[6:0]) ^ odd;
  endfunction
endpackage

//--- src/urd_rx_sampler.sv
// receive pin synchroniser and three-sample majority vote
`timescale 1ns/1ns
module urd_rx_sampler
  import urd_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic pinIn, // raw receive pin
  input wire logic tick, // oversample tick
  output logic level, // voted line level
  output logic clean // all three samples agreed
);
  logic sync1_r;
  logic sync2_r;
  logic [2:0] win_r;
  logic level_r;
  logic clean_r;

  // two-flop synchroniser, line idles high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
    end
  end

  // last three oversample ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_r <= 3'h7;
    end else if (tick) begin
      win_r <= {win_r[1:0], sync2_r};
    end
  end

  // majority and agreement of the window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= 1'b1;
      clean_r <= 1'b1;
    end else begin
      level_r <= (win_r[0] & win_r[1]) | (win_r[0] & win_r[2]) | (win_r[1] & win_r[2]);
      clean_r <= (&win_r) | ~(|win_r);
    end
  end

  assign level = level_r;
  assign clean = clean_r;
endmodule

//--- src/urd_rx_fifo.sv
// two-entry receive word buffer, head word comes from a register
`timescale 1ns/1ns
module urd_rx_fifo
  import urd_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic push, // store a received word
  input wire logic [8:0] pushData, // received word, ninth bit on top
  input wire logic pop, // drop the head word
  output logic [8:0] headData, // oldest word
  output logic [1:0] count // words held
);
  logic [8:0] head_r;
  logic [8:0] tail_r;
  logic [1:0] count_r;
  logic doPush;
  logic doPop;

  assign doPop = pop & (count_r != 2'h0);
  assign doPush = push & (count_r != FIFO_FULL);

  // head entry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      head_r <= 9'h000;
    end else if (doPop) begin
      head_r <= (doPush && count_r == 2'h1) ? pushData : tail_r;
    end else if (doPush && count_r == 2'h0) begin
      head_r <= pushData;
    end
  end

  // second entry and fill count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tail_r <= 9'h000;
      count_r <= 2'h0;
    end else begin
      if (doPush && (doPop ? count_r == FIFO_FULL : count_r == 2'h1)) begin
        tail_r <= pushData;
      end
      count_r <= count_r + {1'b0, doPush} - {1'b0, doPop};
    end
  end

  assign headData = head_r;
  assign count = count_r;
endmodule

//--- src/urd_datapath.sv
// serial port transmit and receive datapath with avalon-mm register slave
// Behaviour
// - transmit pin shifts each word out least significant bit first
// - nine-bit mode sends the stored transmit ninth bit as top data bit
// - status access then data write clears buffer-empty and idle flags; the code needs the status access only for the idle flag
// - data writes are ignored while the buffer-empty flag is low
// - buffer-empty flag set when buffer empty; requests interrupt if enabled
// - write during a frame waits in buffer until that frame ends
// - write while idle loads shifter, starts frame, keeps buffer-empty set
// - transmit idle flag sets when a frame or break frame completes
// - break bit held over divisor plus one clocks while idle arms a break
// - break is start bit, thirteen times N zero bits, then stop bits
// - sending a break raises no transmit interrupt
// - breaks repeat while break bit high; after clearing, finish and stop
// - receiver takes eight or nine bits; ninth bit shows in control register
// - recovery runs at sixteen ticks per bit with three-sample majority vote
// - after stop sample the word moves into the buffer if room
// - receive buffer holds two words while a third shifts in
// - third word arriving with buffer full is dropped and sets overrun
// - receiver hunts for a start bit once enabled, after first seeing a high line
// - data-available flag shows buffered data and requests interrupt if enabled
// - status access then data read clears data-available once buffer drains; the code pops on any data read, no status access needed
// - break ends after data bits plus one stop; zeros stored, framing set
// - after a break wait for a high line before hunting again
// - receiver checks exactly one stop bit
// - transmit pin rests high when nothing is sent
// - status access then data read clears the overrun flag
`timescale 1ns/1ns
module urd_datapath
  import urd_pkg::*;
(
  input wire logic clk, // 50 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [3:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [3:0] avs_byteenable, // byte lanes
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic serialInPin, // receive line
  output logic serialOutPin, // transmit line
  output logic txIrqReq, // transmit empty request
  output logic rxIrqReq // receive request
);
  logic waitReq_r;
  logic [31:0] readData_r;
  logic [15:0] ctrl_r;
  logic [7:0] baud_r;
  logic statusSeen_r;
  logic [7:0] divCnt_r;
  logic tick_r;
  urd_tx_state_e txState_r;
  logic [8:0] txBuf_r;
  logic [8:0] txShift_r;
  logic [3:0] txPhase_r;
  logic [3:0] txBitCnt_r;
  logic txBreak_r;
  logic txEmpty_r;
  logic txIdle_r;
  logic [8:0] brkHold_r;
  logic brkArm_r;
  logic serialOut_r;
  urd_rx_state_e rxState_r;
  logic [3:0] rxPhase_r;
  logic [3:0] rxBitCnt_r;
  logic [8:0] rxShift_r;
  logic rxNoise_r;
  logic overrun_r;
  logic noise_r;
  logic frame_r;
  logic parity_r;
  logic txIrq_r;
  logic rxIrq_r;
  logic busReq, acc, dataWr, dataRd, statAcc, ctrlWr, baudWr;
  logic txEn, rxEn, word9, sendBreak;
  logic [3:0] lastBit;
  logic [8:0] txFrame;
  logic txAccept, txLoadDirect, txBitEnd, stopEnd, txLoadBuf;
  logic rxLevel, rxClean, rxSample, rxDone, rxPush, rxOverrun, rxFrameErr;
  logic rxNoiseNow, rxParErr;
  logic [8:0] rxWord;
  logic [8:0] rxHead;
  logic [1:0] rxCount;
  logic [15:0] ctrlMask;
  logic [15:0] ctrlView;
  logic [7:0] statView;

  // bus decode; every access takes one wait state
  assign busReq = avs_read | avs_write;
  assign acc = busReq & ~waitReq_r;
  assign dataWr = acc & avs_write & (avs_address == ADDR_DATA) & avs_byteenable[0];
  assign dataRd = acc & avs_read & (avs_address == ADDR_DATA);
  assign statAcc = acc & (avs_address == ADDR_STAT);
  assign ctrlWr = acc & avs_write & (avs_address == ADDR_CTRL);
  assign baudWr = acc & avs_write & (avs_address == ADDR_BAUD) & avs_byteenable[0];
  assign ctrlMask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & CTRL_WR_MASK;

  // control field aliases
  assign txEn = ctrl_r[CTRL_TX_EN];
  assign rxEn = ctrl_r[CTRL_RX_EN];
  assign word9 = ctrl_r[CTRL_WORD9];
  assign sendBreak = ctrl_r[CTRL_BREAK];
  assign lastBit = word9 ? LAST_BIT9 : LAST_BIT8;

  // outgoing word with ninth bit and optional parity in place
  always_comb begin
    txFrame = {ctrl_r[CTRL_TX_NINTH], avs_writedata[7:0]};
    if (ctrl_r[CTRL_PAR_EN]) begin
      if (word9) begin
        txFrame[8] = urd_par(txFrame, 1'b1, ctrl_r[CTRL_PAR_ODD]);
      end else begin
        txFrame[7] = urd_par(txFrame, 1'b0, ctrl_r[CTRL_PAR_ODD]);
      end
    end
    if (!word9) begin
      txFrame[8] = 1'b0;
    end
  end

  // register views
  always_comb begin
    ctrlView = ctrl_r;
    ctrlView[CTRL_RX_NINTH] = rxHead[8];
    statView = 8'h00;
    statView[STAT_TX_EMPTY] = txEmpty_r;
    statView[STAT_TX_IDLE] = txIdle_r;
    statView[STAT_RX_AVAIL] = (rxCount != 2'h0);
    statView[STAT_OVERRUN] = overrun_r;
    statView[STAT_NOISE] = noise_r;
    statView[STAT_FRAME] = frame_r;
    statView[STAT_PARITY] = parity_r;
    statView[STAT_RX_IDLE] = (rxState_r == RX_WAITHIGH) || (rxState_r == RX_HUNT);
  end

  // wait state and read data, ready at the edge waitrequest is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReq_r <= 1'b1;
      readData_r <= 32'h0000_0000;
    end else begin
      waitReq_r <= ~(busReq & waitReq_r);
      if (busReq && waitReq_r && avs_read) begin
        unique case (avs_address)
          ADDR_DATA: readData_r <= {24'h00_0000, rxHead[7:0]};
          ADDR_CTRL: readData_r <= {16'h0000, ctrlView};
          ADDR_STAT: readData_r <= {24'h00_0000, statView};
          ADDR_BAUD: readData_r <= {24'h00_0000, baud_r};
          default: readData_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
      baud_r <= BAUD_RESET;
    end else begin
      if (ctrlWr) begin
        ctrl_r <= (ctrl_r & ~ctrlMask) | (avs_writedata[15:0] & ctrlMask);
      end
      if (baudWr) begin
        baud_r <= avs_writedata[7:0];
      end
    end
  end

  // status access arms the clearing sequence, a data read or a data write with byte lane 0 enabled ends it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      statusSeen_r <= 1'b0;
    end else if (statAcc) begin
      statusSeen_r <= 1'b1;
    end else if (dataWr || dataRd) begin
      statusSeen_r <= 1'b0;
    end
  end

  // oversample tick, sixteen per bit time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (divCnt_r == baud_r);
      divCnt_r <= (divCnt_r == baud_r) ? 8'h00 : divCnt_r + 8'h01;
    end
  end

  // transmit events
  assign txAccept = dataWr & txEmpty_r;
  assign txLoadDirect = txAccept & txEn & (txState_r == TX_IDLE) & ~brkArm_r;
  assign txBitEnd = tick_r & (txPhase_r == OVS_LAST);
  assign stopEnd = (txState_r == TX_STOP) & txBitEnd &
                   (txBitCnt_r == {3'h0, ctrl_r[CTRL_STOP2]});
  assign txLoadBuf = txEn & ~txEmpty_r &
                     (stopEnd | ((txState_r == TX_IDLE) & ~brkArm_r));

  // break request must be held over divisor plus one clocks while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brkHold_r <= 9'h000;
      brkArm_r <= 1'b0;
    end else begin
      if (sendBreak && txState_r == TX_IDLE && !brkArm_r) begin
        brkHold_r <= brkHold_r + 9'h001;
      end else begin
        brkHold_r <= 9'h000;
      end
      // the starting break consumes the arm, so a stale hold count cannot re-arm it
      if (brkArm_r && txEn && txState_r == TX_IDLE) begin
        brkArm_r <= 1'b0;
      end else if (brkHold_r > {1'b0, baud_r}) begin
        brkArm_r <= 1'b1;
      end
    end
  end

  // transmit sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_r <= TX_IDLE;
      txShift_r <= 9'h000;
      txPhase_r <= 4'h0;
      txBitCnt_r <= 4'h0;
      txBreak_r <= 1'b0;
    end else if (!txEn) begin
      txState_r <= TX_IDLE;
      txPhase_r <= 4'h0;
      txBreak_r <= 1'b0;
    end else begin
      if (txState_r != TX_IDLE && tick_r) begin
        txPhase_r <= txPhase_r + 4'h1;
      end
      unique case (txState_r)
        TX_IDLE: begin
          txPhase_r <= 4'h0;
          txBitCnt_r <= 4'h0;
          if (brkArm_r) begin
            txBreak_r <= 1'b1;
            txState_r <= TX_START;
          end else if (txLoadDirect) begin
            txShift_r <= txFrame;
            txBreak_r <= 1'b0;
            txState_r <= TX_START;
          end else if (txLoadBuf) begin
            txShift_r <= txBuf_r;
            txBreak_r <= 1'b0;
            txState_r <= TX_START;
          end
        end
        TX_START: begin
          if (txBitEnd) begin
            txState_r <= txBreak_r ? TX_BREAK : TX_DATA;
          end
        end
        TX_DATA: begin
          if (txBitEnd) begin
            txShift_r <= {1'b0, txShift_r[8:1]};
            txBitCnt_r <= txBitCnt_r + 4'h1;
            if (txBitCnt_r == lastBit) begin
              txBitCnt_r <= 4'h0;
              txState_r <= TX_STOP;
            end
          end
        end
        TX_BREAK: begin
          if (txBitEnd) begin
            txBitCnt_r <= txBitCnt_r + 4'h1;
            if (txBitCnt_r == BREAK_LAST) begin
              txBitCnt_r <= 4'h0;
              txState_r <= sendBreak ? TX_BREAK : TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (stopEnd) begin
            txBreak_r <= 1'b0;
            txBitCnt_r <= 4'h0;
            txShift_r <= txBuf_r;
            txState_r <= txLoadBuf ? TX_START : TX_IDLE;
          end else if (txBitEnd) begin
            txBitCnt_r <= txBitCnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  // transmit line level, high whenever no bit is driven low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serialOut_r <= 1'b1;
    end else begin
      unique case (txState_r)
        TX_START: serialOut_r <= 1'b0;
        TX_BREAK: serialOut_r <= 1'b0;
        TX_DATA: serialOut_r <= txShift_r[0];
        default: serialOut_r <= 1'b1;
      endcase
    end
  end

  // transmit buffer and its flags; set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBuf_r <= 9'h000;
      txEmpty_r <= 1'b1;
      txIdle_r <= 1'b1;
    end else begin
      if (txAccept && !txLoadDirect) begin
        txBuf_r <= txFrame;
      end
      if (txLoadBuf) begin
        txEmpty_r <= 1'b1;
      end else if (txAccept && !txLoadDirect) begin
        txEmpty_r <= 1'b0;
      end
      if (stopEnd) begin
        txIdle_r <= 1'b1;
      end else if (txAccept && statusSeen_r) begin
        txIdle_r <= 1'b0;
      end
    end
  end

  // receive line recovery
  urd_rx_sampler u_sampler (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn(serialInPin),
    .tick(tick_r),
    .level(rxLevel),
    .clean(rxClean)
  );

  // receive events at the stop sample
  assign rxSample = tick_r & (rxPhase_r == RX_SAMPLE_PHASE);
  assign rxDone = (rxState_r == RX_STOP) & rxSample;
  assign rxWord = word9 ? rxShift_r : {1'b0, rxShift_r[8:1]};
  assign rxFrameErr = ~rxLevel;
  assign rxNoiseNow = rxNoise_r | ~rxClean;
  assign rxParErr = ctrl_r[CTRL_PAR_EN] &
                    ((word9 ? rxWord[8] : rxWord[7]) != urd_par(rxWord, word9, ctrl_r[CTRL_PAR_ODD]));
  assign rxPush = rxDone & (rxCount != FIFO_FULL);
  assign rxOverrun = rxDone & (rxCount == FIFO_FULL);

  // receive sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_r <= RX_WAITHIGH;
      rxPhase_r <= 4'h0;
      rxBitCnt_r <= 4'h0;
      rxShift_r <= 9'h000;
      rxNoise_r <= 1'b0;
    end else if (!rxEn) begin
      rxState_r <= RX_WAITHIGH;
    end else begin
      if (tick_r) begin
        rxPhase_r <= rxPhase_r + 4'h1;
      end
      unique case (rxState_r)
        RX_WAITHIGH: begin
          if (tick_r && rxLevel) begin
            rxState_r <= RX_HUNT;
          end
        end
        RX_HUNT: begin
          rxPhase_r <= 4'h0;
          rxBitCnt_r <= 4'h0;
          rxNoise_r <= 1'b0;
          if (tick_r && !rxLevel) begin
            rxState_r <= RX_START;
          end
        end
        RX_START: begin
          if (rxSample) begin
            rxNoise_r <= ~rxClean;
            rxState_r <= rxLevel ? RX_HUNT : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxSample) begin
            rxShift_r <= {rxLevel, rxShift_r[8:1]};
            rxNoise_r <= rxNoiseNow;
            rxBitCnt_r <= rxBitCnt_r + 4'h1;
            if (rxBitCnt_r == lastBit) begin
              rxState_r <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rxDone) begin
            rxState_r <= rxFrameErr ? RX_WAITHIGH : RX_HUNT;
          end
        end
      endcase
    end
  end

  // two-word receive buffer
  urd_rx_fifo u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .push(rxPush),
    .pushData(rxWord),
    .pop(dataRd),
    .headData(rxHead),
    .count(rxCount)
  );

  // receive error flags; hardware set wins over the clearing read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_r <= 1'b0;
      noise_r <= 1'b0;
      frame_r <= 1'b0;
      parity_r <= 1'b0;
    end else begin
      if (rxOverrun) begin
        overrun_r <= 1'b1;
      end else if (dataRd && statusSeen_r) begin
        overrun_r <= 1'b0;
      end
      if (rxPush) begin
        noise_r <= noise_r | rxNoiseNow;
        frame_r <= frame_r | rxFrameErr;
        parity_r <= parity_r | rxParErr;
      end else if (dataRd && statusSeen_r) begin
        noise_r <= 1'b0;
        frame_r <= 1'b0;
        parity_r <= 1'b0;
      end
    end
  end

  // interrupt request levels; no transmit request while a break is on the line
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txIrq_r <= 1'b0;
      rxIrq_r <= 1'b0;
    end else begin
      txIrq_r <= ctrl_r[CTRL_TX_IRQ_EN] & txEmpty_r & ~txBreak_r;
      rxIrq_r <= ctrl_r[CTRL_RX_IRQ_EN] & ((rxCount != 2'h0) | overrun_r);
    end
  end

  assign avs_readdata = readData_r;
  assign avs_waitrequest = waitReq_r;
  assign serialOutPin = serialOut_r;
  assign txIrqReq = txIrq_r;
  assign rxIrqReq = rxIrq_r;

  // checks
  property p_lsbFirst;
    @(posedge clk) disable iff (!rst_n)
    (txState_r == TX_DATA) |=> (serialOut_r == $past(txShift_r[0]));
  endproperty
  a_lsbFirst: assert property (p_lsbFirst) else $error("data bit not lsb of shifter");
  property p_restHigh;
    @(posedge clk) disable iff (!rst_n)
    (txState_r == TX_IDLE) [*2] |-> serialOut_r;
  endproperty
  a_restHigh: assert property (p_restHigh) else $error("idle line not high");
  property p_blockWrite;
    @(posedge clk) disable iff (!rst_n)
    (dataWr && !txEmpty_r) |=> $stable(txBuf_r) && (txEmpty_r == $past(txLoadBuf));
  endproperty
  a_blockWrite: assert property (p_blockWrite) else $error("write overwrote buffer");
  property p_directLoad;
    @(posedge clk) disable iff (!rst_n)
    txLoadDirect |=> txEmpty_r && (txState_r == TX_START) ##16 !serialOut_r;
  endproperty
  a_directLoad: assert property (p_directLoad) else $error("direct load failed");
  property p_buffered;
    @(posedge clk) disable iff (!rst_n)
    (txAccept && !txLoadDirect && !txLoadBuf) |=> !txEmpty_r;
  endproperty
  a_buffered: assert property (p_buffered) else $error("buffered write lost");
  property p_idleSet;
    @(posedge clk) disable iff (!rst_n)
    stopEnd |=> txIdle_r;
  endproperty
  a_idleSet: assert property (p_idleSet) else $error("idle flag not set");
  property p_breakEnd;
    @(posedge clk) disable iff (!rst_n)
    (txState_r == TX_BREAK && txBitEnd && txBitCnt_r == BREAK_LAST && !sendBreak && txEn)
      |=> (txState_r == TX_STOP);
  endproperty
  a_breakEnd: assert property (p_breakEnd) else $error("break not ended");
  property p_breakNoIrq;
    @(posedge clk) disable iff (!rst_n)
    (txBreak_r && $past(txBreak_r)) |-> !txIrq_r;
  endproperty
  a_breakNoIrq: assert property (p_breakNoIrq) else $error("irq during break");
  property p_overrun;
    @(posedge clk) disable iff (!rst_n)
    rxOverrun |=> overrun_r && (rxCount == FIFO_FULL || $past(dataRd));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");
  property p_busAnswer;
    @(posedge clk) disable iff (!rst_n)
    (busReq && waitReq_r) |=> !waitReq_r ##1 waitReq_r;
  endproperty
  a_busAnswer: assert property (p_busAnswer) else $error("bus answer not one wait state");
endmodule

//--- dv/urd_remote.sv
// remote serial device model: sends and captures frames
`timescale 1ns/1ns
module urd_remote (
  input wire logic clk, // system clock
  input wire logic lineIn, // from transmit pin
  output logic lineOut // to receive pin
);
  // line rests high between frames
  initial lineOut = 1'b1;
  // start, eight bits lsb first, one stop, 16 clocks each
  task automatic sendWord(input logic [7:0] w);
    for (int i = -1; i < 9; i++) begin
      lineOut <= (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : w[i];
      repeat (16) @(posedge clk);
    end
  endtask
  // line held low for a number of bit times, then high again
  task automatic sendBreak(input int bits);
    lineOut <= 1'b0;
    repeat (bits * 16) @(posedge clk);
    lineOut <= 1'b1;
    repeat (32) @(posedge clk);
  endtask
  // hunt for a start bit, then sample mid-bit
  task automatic getWord(output logic [7:0] w, output logic ok);
    int n = 0;
    while (lineIn !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    ok = (n < 2000);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk);
      w[i] = lineIn;
    end
    repeat (16) @(posedge clk);
  endtask
endmodule

//--- dv/test_urd_datapath.sv
// self-checking bench for the serial port datapath
`timescale 1ns/1ns
module test_urd_datapath;
  import urd_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic rd = 0;
  logic wr = 0;
  logic txPin, rxPin, txIrq, rxIrq, waitReq, ok;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, q;
  logic [7:0] got;
  int error_cnt = 0;
  int checks = 0;
  int n = 0;
  logic [3:0] rowA [4] = '{ADDR_STAT, ADDR_CTRL, ADDR_BAUD, 4'h2};
  logic [31:0] rowE [4] = '{32'h83, 32'h0, 32'h0, 32'h0};
  // 50 MHz clock
  always #10 clk = ~clk;
  urd_datapath dut (.clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_byteenable(4'hF), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .serialInPin(rxPin), .serialOutPin(txPin),
    .txIrqReq(txIrq), .rxIrqReq(rxIrq));
  urd_remote remote (.clk(clk), .lineIn(txPin), .lineOut(rxPin));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // print counts and verdict
  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one bus access held until waitrequest is seen low
  task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitReq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      final_report();
    end
    @(posedge clk);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      acc(rowA[i], 1'b0, 32'h0);
      chk(q, rowE[i]);
    end
    acc(ADDR_BAUD, 1'b1, 32'h0);
    acc(ADDR_CTRL, 1'b1, 32'h6C0);
    chk(txPin, 32'h1);
    acc(ADDR_STAT, 1'b0, 32'h0);
    chk(txIrq, 32'h1);
    fork
      remote.getWord(got, ok);
      begin
        acc(ADDR_DATA, 1'b1, 32'hA5);
        acc(ADDR_STAT, 1'b0, 32'h0);
        chk(q & 32'h3, 32'h1);
        acc(ADDR_DATA, 1'b1, 32'h5A);
        acc(ADDR_STAT, 1'b0, 32'h0);
        chk(q & 32'h1, 32'h0);
        acc(ADDR_DATA, 1'b1, 32'hFF);
      end
    join
    chk(got, 32'hA5);
    chk(ok, 32'h1);
    remote.getWord(got, ok);
    chk(got, 32'h5A);
    chk(ok, 32'h1);
    remote.getWord(got, ok);
    chk(ok, 32'h0);
    acc(ADDR_STAT, 1'b0, 32'h0);
    chk(q, 32'h83);
    remote.sendWord(8'h3C);
    acc(ADDR_STAT, 1'b0, 32'h0);
    chk(q & 32'h4, 32'h4);
    chk(rxIrq, 32'h1);
    acc(ADDR_DATA, 1'b0, 32'h0);
    chk(q, 32'h3C);
    acc(ADDR_STAT, 1'b0, 32'h0);
    chk(q & 32'h4, 32'h0);
    chk(rxIrq, 32'h0);
    for (int i = 1; i < 4; i++) begin
      remote.sendWord(8'(i * 17));
    end
    acc(ADDR_STAT, 1'b0, 32'h0);
    chk(q & 32'hC, 32'hC);
    acc(ADDR_DATA, 1'b0, 32'h0);
    chk(q, 32'h11);
    acc(ADDR_DATA, 1'b0, 32'h0);
    chk(q, 32'h22);
    acc(ADDR_STAT, 1'b0, 32'h0);
    chk(q & 32'hC, 32'h0);
    // transmit break: armed by a short hold, released at once
    acc(ADDR_CTRL, 1'b1, 32'h7C0);
    acc(ADDR_CTRL, 1'b1, 32'h6C0);
    n = 0;
    while (txPin !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(txIrq, 32'h0);
    n = 0;
    while (txPin === 1'b0 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    chk(n, 32'hE0);
    repeat (24) @(posedge clk);
    chk(txPin, 32'h1);
    chk(txIrq, 32'h1);
    // long received break: one zero word, framing set, no restart on the low line
    remote.sendBreak(20);
    acc(ADDR_STAT, 1'b0, 32'h0);
    chk(q & 32'hA4, 32'hA4);
    acc(ADDR_DATA, 1'b0, 32'h0);
    chk(q, 32'h0);
    acc(ADDR_STAT, 1'b0, 32'h0);
    chk(q & 32'h24, 32'h0);
    // reset in mid-run returns every flag to its idle value
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    acc(ADDR_STAT, 1'b0, 32'h0);
    chk(q, 32'h83);
    chk(txPin, 32'h1);
    final_report();
  end
endmodule
